// file: rtl/fpp_regs.svh
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets in the data file
// ----------------------------------------------------------------
`define FPP_OFS_STATUS 5'h03
`define FPP_OFS_PORT 5'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPP_ST_PIN_WAKE 7
`define FPP_ST_CMP_WAKE 6
`define FPP_OPT_WAKE_N 7
`define FPP_OPT_PULL_N 6
`define FPP_OPT_TMR_EXT 5
`define FPP_PIN_MASTER_CLEAR 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FPP_DIR_RST 4'hF
`define FPP_OPT_RST 8'hFF
`define FPP_LATCH_RST 4'h0

`endif

// file: rtl/fpp_pkg.sv
package fpp_pkg;

  // Wake-on-change tracker states
  typedef enum logic [2:0] {
    FPP_WK_RUN   = 3'b001,
    FPP_WK_ARMED = 3'b010,
    FPP_WK_FIRED = 3'b100
  } fpp_wake_e;

  typedef logic [7:0] fpp_byte_t;
  typedef logic [3:0] fpp_nib_t;

endpackage

// file: rtl/fpp_mux_if.sv
`timescale 1ns/1ns
// Pin function selection between port core and pin mux
interface fpp_mux_if;
  logic [3:0] dir;
  logic [3:0] latch;
  logic cmp_en;
  logic cmp_out_en;
  logic cmp_out;
  logic osc_q_en;
  logic osc_q;
  logic tmr_ext;
  logic [2:0] drv_val;
  logic [2:0] drv_oe;
  logic tmr_ext_sel;

  modport core (
    output dir, latch, cmp_en, cmp_out_en, cmp_out,
    output osc_q_en, osc_q, tmr_ext,
    input drv_val, drv_oe, tmr_ext_sel
  );
  modport mux (
    input dir, latch, cmp_en, cmp_out_en, cmp_out,
    input osc_q_en, osc_q, tmr_ext,
    output drv_val, drv_oe, tmr_ext_sel
  );
endinterface

// file: rtl/fpp_sync.sv
`timescale 1ns/1ns
// Three-stage pin synchroniser; a change is taken once the
// second and third stages agree, which drops one-cycle glitches.
module fpp_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1) begin : g_chk
    $error("fpp_sync: W must be at least 1");
  end

  // Shift chain; only s2 reads s1
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept per bit when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// file: rtl/fpp_pinmux.sv
`timescale 1ns/1ns
// Pin function precedence for the three drivable pins
module fpp_pinmux (
  fpp_mux_if.mux mx
);
  // ------------------------------------------------------------
  // Precedence
  // ------------------------------------------------------------
  always_comb begin
    // RULE10 - pin zero comparator
    if (mx.cmp_en) begin
      mx.drv_oe[0] = 1'b0;
    end else begin
      mx.drv_oe[0] = ~mx.dir[0];
    end
    mx.drv_val[0] = mx.latch[0];
    // RULE10 - pin one comparator
    if (mx.cmp_en) begin
      mx.drv_oe[1] = 1'b0;
    end else begin
      mx.drv_oe[1] = ~mx.dir[1];
    end
    mx.drv_val[1] = mx.latch[1];
    // RULE10 - pin two order
    mx.tmr_ext_sel = 1'b0;
    if (mx.osc_q_en) begin
      mx.drv_oe[2] = 1'b1;
      mx.drv_val[2] = mx.osc_q;
    end else if (mx.cmp_out_en) begin
      mx.drv_oe[2] = 1'b1;
      mx.drv_val[2] = mx.cmp_out;
    end else if (mx.tmr_ext) begin
      mx.drv_oe[2] = 1'b0;
      mx.drv_val[2] = mx.latch[2];
      mx.tmr_ext_sel = 1'b1;
    end else begin
      // RULE8 - direction sets driver
      mx.drv_oe[2] = ~mx.dir[2];
      mx.drv_val[2] = mx.latch[2];
    end
  end
endmodule

// file: rtl/fpp_port.sv
`timescale 1ns/1ns
`include "fpp_regs.svh"

// Contract
// RULE1 - Port reads return present pin levels, never the latches.
// RULE2 - Any reset sets every direction bit, so all pins float.
// RULE3 - Port value is eight bits; bits 7 to 4 read zero.
// RULE4 - Pin 3 is input only; its driver never turns on.
// RULE5 - Pins 0, 1, 3 get pull-ups and wake-on-change, global.
// RULE6 - In master clear mode pin 3 pulls up, no wake.
// RULE7 - Direction-load instruction copies working register into direction.
// RULE8 - Direction 1 floats the driver; 0 drives the latch value.
// RULE9 - Direction register is write-only, never readable.
// RULE10 - Pin function precedence per pin as fixed in the mux.
// RULE11 - External inputs stay stable until the read samples them.
// RULE12 - Output latches hold until software writes them again.
// RULE13 - Pins 0 to 2 each have their own direction bit.
// RULE14 - Pin-change wake flag set only on pin-change wake reset.
// RULE15 - Comparator wake flag set only on comparator wake reset.
// RULE16 - Writes land at cycle end; reads sample at cycle start.
// RULE17 - Bit set/clear read pins, modify, write all latches.
// RULE18 - Port write loads latches; pin 3 latch drives nothing.
module fpp_port #(
  parameter int PIN_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic bit_set,
  input wire logic bit_clr,
  input wire logic [2:0] bit_sel,
  input wire logic dir_load,
  input wire logic opt_load,
  input wire logic [7:0] w_reg,
  input wire logic cause_pin_wake,
  input wire logic cause_cmp_wake,
  input wire logic master_clear_mode,
  input wire logic sleep_mode,
  input wire logic cmp_en,
  input wire logic cmp_out_en,
  input wire logic cmp_out,
  input wire logic osc_q_en,
  input wire logic osc_q,
  input wire logic [3:0] pin_in,
  output logic [7:0] reg_rdata,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [3:0] pull_en,
  output logic tmr_ext_sel,
  output logic wake_req
);
  if (PIN_W != 4) begin : g_chk
    $error("fpp_port: only four pins are supported");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic fpp_pkg::fpp_nib_t bit_mask(
    input logic [2:0] sel
  );
    bit_mask = 4'h0;
    if (sel < 3'h4) begin
      bit_mask[sel[1:0]] = 1'b1;
    end
  endfunction

  fpp_pkg::fpp_nib_t pin_s;
  fpp_pkg::fpp_nib_t dir_r;
  fpp_pkg::fpp_nib_t latch_r;
  fpp_pkg::fpp_nib_t latch_nxt;
  fpp_pkg::fpp_nib_t wake_mask;
  fpp_pkg::fpp_nib_t ref_r;
  fpp_pkg::fpp_byte_t opt_r;
  fpp_pkg::fpp_wake_e wk_r;
  fpp_pkg::fpp_wake_e wk_nxt;
  logic pin_wuf_r;
  logic cmp_wuf_r;
  logic port_sel;
  logic wake_on;
  logic pins_moved;

  fpp_mux_if mxi ();

  // ------------------------------------------------------------
  // Pin input synchroniser
  // ------------------------------------------------------------
  // RULE11 - pins not latched
  fpp_sync #(
    .W(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d_in(pin_in),
    .q_out(pin_s)
  );

  assign port_sel = (reg_addr == `FPP_OFS_PORT);

  // ------------------------------------------------------------
  // Direction and option registers
  // ------------------------------------------------------------
  // RULE2 - reset floats pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_r <= `FPP_DIR_RST;
    end else if (dir_load) begin
      // RULE7 - load from working reg
      dir_r <= w_reg[3:0];
    end
  end

  // Option register is also write-only; loaded by its instruction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opt_r <= `FPP_OPT_RST;
    end else if (opt_load) begin
      opt_r <= w_reg;
    end
  end

  // ------------------------------------------------------------
  // Output latches
  // ------------------------------------------------------------
  // Bit ops use the synchronised pins, so an input pin's level
  // can overwrite its latch; that is the documented hazard.
  always_comb begin
    latch_nxt = latch_r;
    if (port_sel && reg_wr) begin
      // RULE18 - write loads latches
      latch_nxt = reg_wdata[3:0];
    end else if (port_sel && bit_set) begin
      // RULE17 - read modify write
      latch_nxt = pin_s | bit_mask(bit_sel);
    end else if (port_sel && bit_clr) begin
      // RULE17 - read modify write
      latch_nxt = pin_s & ~bit_mask(bit_sel);
    end
  end

  // RULE16 - latch at cycle end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_r <= `FPP_LATCH_RST;
    end else begin
      // RULE12 - hold unless written
      latch_r <= latch_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  assign mxi.dir = dir_r;
  assign mxi.latch = latch_r;
  assign mxi.cmp_en = cmp_en;
  assign mxi.cmp_out_en = cmp_out_en;
  assign mxi.cmp_out = cmp_out;
  assign mxi.osc_q_en = osc_q_en;
  assign mxi.osc_q = osc_q;
  assign mxi.tmr_ext = opt_r[`FPP_OPT_TMR_EXT];

  fpp_pinmux u_mux (
    .mx(mxi.mux)
  );

  // RULE13 - per pin direction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_oe <= 3'h0;
      pin_out <= 3'h0;
      tmr_ext_sel <= 1'b0;
    end else begin
      // RULE4 - no pin 3 driver
      pin_oe <= mxi.drv_oe;
      pin_out <= mxi.drv_val;
      tmr_ext_sel <= mxi.tmr_ext_sel;
    end
  end

  // ------------------------------------------------------------
  // Pull-ups
  // ------------------------------------------------------------
  // RULE5 - global pull-up enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pull_en <= 4'h0;
    end else begin
      pull_en[0] <= ~opt_r[`FPP_OPT_PULL_N];
      pull_en[1] <= ~opt_r[`FPP_OPT_PULL_N];
      pull_en[2] <= 1'b0;
      // RULE6 - forced pull-up
      pull_en[3] <= ~opt_r[`FPP_OPT_PULL_N] | master_clear_mode;
    end
  end

  // ------------------------------------------------------------
  // Wake on change
  // ------------------------------------------------------------
  // RULE6 - no master clear wake
  assign wake_mask = {~master_clear_mode, 1'b0, 1'b1, 1'b1};
  assign wake_on = ~opt_r[`FPP_OPT_WAKE_N];
  assign pins_moved = |((pin_s ^ ref_r) & wake_mask);

  // Reference is taken at sleep entry, not continuously
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_r <= 4'h0;
    end else if (wk_r == fpp_pkg::FPP_WK_RUN && sleep_mode) begin
      ref_r <= pin_s;
    end
  end

  // RULE5 - global wake enable
  always_comb begin
    wk_nxt = wk_r;
    unique case (wk_r)
      fpp_pkg::FPP_WK_RUN: begin
        if (sleep_mode) begin
          wk_nxt = fpp_pkg::FPP_WK_ARMED;
        end
      end
      fpp_pkg::FPP_WK_ARMED: begin
        if (!sleep_mode) begin
          wk_nxt = fpp_pkg::FPP_WK_RUN;
        end else if (wake_on && pins_moved) begin
          wk_nxt = fpp_pkg::FPP_WK_FIRED;
        end
      end
      fpp_pkg::FPP_WK_FIRED: begin
        if (!sleep_mode) begin
          wk_nxt = fpp_pkg::FPP_WK_RUN;
        end
      end
      default: begin
        wk_nxt = fpp_pkg::FPP_WK_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wk_r <= fpp_pkg::FPP_WK_RUN;
      wake_req <= 1'b0;
    end else begin
      wk_r <= wk_nxt;
      wake_req <= (wk_nxt == fpp_pkg::FPP_WK_FIRED);
    end
  end

  // ------------------------------------------------------------
  // Wake cause flags
  // ------------------------------------------------------------
  // Captured while reset is held, so the cause reads afterwards
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // RULE14 - pin wake cause
      pin_wuf_r <= cause_pin_wake;
      // RULE15 - comparator wake cause
      cmp_wuf_r <= cause_cmp_wake;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // RULE9 - direction never decoded
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (port_sel) begin
        // RULE1 - pins, not latches
        // RULE3 - upper bits zero
        reg_rdata <= {4'h0, pin_s};
      end else if (reg_addr == `FPP_OFS_STATUS) begin
        reg_rdata <= {pin_wuf_r, cmp_wuf_r, 6'h00};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_armed_move;
    wk_r == fpp_pkg::FPP_WK_ARMED && sleep_mode ##0 wake_on && pins_moved;
  endsequence
  sequence s_wake_held;
    wake_req [*2];
  endsequence

  AST_READ_PINS: assert property ( // RULE1
    reg_rd && port_sel |=> reg_rdata[3:0] == $past(pin_s))
    else $error("port read did not return pin levels");
  AST_RST_FLOAT: assert property ( // RULE2
    disable iff (1'b0) rst |=> pin_oe == 3'h0 && dir_r == 4'hF)
    else $error("reset left a driver on");
  AST_UPPER_ZERO: assert property ( // RULE3
    reg_rd && port_sel |=> reg_rdata[7:4] == 4'h0)
    else $error("unimplemented port bits not zero");
  AST_DIR_LOAD: assert property ( // RULE7
    dir_load |=> dir_r == $past(w_reg[3:0]))
    else $error("direction not loaded from working reg");
  AST_DIR_DRIVE: assert property ( // RULE8
    !cmp_en && !dir_r[1] |=> pin_oe[1] && pin_out[1] == $past(latch_r[1]))
    else $error("cleared direction bit did not drive latch");
  AST_LATCH_HOLD: assert property ( // RULE12
    !(port_sel && (reg_wr || bit_set || bit_clr)) |=> $stable(latch_r))
    else $error("latch changed without a write");
  AST_MASTER_PULL: assert property ( // RULE6
    master_clear_mode ##1 master_clear_mode |-> pull_en[3])
    else $error("pin 3 pull-up off in master clear mode");
  AST_OSC_FIRST: assert property ( // RULE10
    osc_q_en |=> pin_oe[2] && pin_out[2] == $past(osc_q))
    else $error("oscillator output lost precedence on pin 2");
  AST_WAKE_FIRE: assert property ( // RULE5
    s_armed_move |=> wake_req ##1 (wake_req || !$past(sleep_mode)))
    else $error("pin change during sleep did not wake");
  AST_NO_WAKE: assert property ( // RULE5
    !wake_on && wk_r != fpp_pkg::FPP_WK_FIRED |=> !wake_req)
    else $error("wake raised while disabled");
  AST_BIT_SET: assert property ( // RULE17
    port_sel && bit_set && !reg_wr |=>
      latch_r == ($past(pin_s) | bit_mask($past(bit_sel))))
    else $error("bit set did not rewrite from pins");
  AST_FLAG_CAUSE: assert property ( // RULE14
    $fell(rst) |-> pin_wuf_r == $past(cause_pin_wake)
      && cmp_wuf_r == $past(cause_cmp_wake))
    else $error("wake flags do not match reset cause");
  AST_WAKE_STICK: assert property ( // RULE5
    wake_req && sleep_mode |-> s_wake_held)
    else $error("wake request dropped while still asleep");
endmodule

// file: tb/fpp_board.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Board circuitry on the far side of the four port pins
// ----------------------------------------------------------------
module fpp_board (
  input wire logic sys_clk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [3:0] pull_en,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_in
);
  logic float_r = 1'b0;
  logic [3:0] dev_oe;
  logic [3:0] dev_val;

  // An open line must not look settled, so it flips every cycle
  always_ff @(posedge sys_clk) begin
    float_r <= ~float_r;
  end

  // Pin 3 has no device driver at all
  assign dev_oe = {1'b0, pin_oe};
  assign dev_val = {1'b0, pin_out};

  // Device driver, then board driver, then pull-up, else open line
  // board holds levels
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_oe[i])
        pin_in[i] = dev_val[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pull_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_r;
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "fpp_regs.svh"
module testbench;
  localparam logic [5:0] WR = 6'h20;
  localparam logic [5:0] RD = 6'h10;
  localparam logic [5:0] BS = 6'h08;
  localparam logic [5:0] BC = 6'h04;
  localparam logic [5:0] DL = 6'h02;
  localparam logic [5:0] OL = 6'h01;
  logic sys_clk, rst, reg_wr, reg_rd, bit_set, bit_clr, dir_load;
  logic opt_load, cause_pin_wake, cause_cmp_wake, master_clear_mode;
  logic sleep_mode, cmp_en, cmp_out_en, cmp_out, osc_q_en, osc_q;
  logic tmr_ext_sel, wake_req, probe;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, w_reg, reg_rdata;
  logic [2:0] bit_sel, pin_out, pin_oe;
  logic [3:0] pin_in, pull_en, ext_en, ext_val;
  logic [7:0] exp_q[$];
  int sel_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'h149F42AC;
  int r;
  string names[7] = '{"reg_rdata", "pin_oe", "pin_out", "pull_en",
                      "tmr_ext_sel", "wake_req", "pin_out2"};

  fpp_port u_fpp_port (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .bit_set(bit_set), .bit_clr(bit_clr),
    .bit_sel(bit_sel), .dir_load(dir_load), .opt_load(opt_load),
    .w_reg(w_reg), .cause_pin_wake(cause_pin_wake),
    .cause_cmp_wake(cause_cmp_wake),
    .master_clear_mode(master_clear_mode),
    .sleep_mode(sleep_mode), .cmp_en(cmp_en), .cmp_out_en(cmp_out_en),
    .cmp_out(cmp_out), .osc_q_en(osc_q_en), .osc_q(osc_q),
    .pin_in(pin_in), .reg_rdata(reg_rdata), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_en(pull_en), .tmr_ext_sel(tmr_ext_sel),
    .wake_req(wake_req));

  fpp_board u_fpp_board (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_en(pull_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Clock, verdict and shared tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
      fail_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Note an expectation; the monitor compares at the next edge
  task automatic look(input int s, input logic [7:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
    probe = 1'b1;
    tick(1);
    probe = 1'b0;
    tick(1);
  endtask

  // One core operation; a spare cycle keeps strobes apart
  task automatic cmd(input logic [5:0] m, input logic [4:0] a,
                     input logic [7:0] d);
    {reg_wr, reg_rd, bit_set, bit_clr, dir_load, opt_load} = m;
    reg_addr = a;
    reg_wdata = d;
    w_reg = d;
    bit_sel = d[2:0];
    tick(1);
    {reg_wr, reg_rd, bit_set, bit_clr, dir_load, opt_load} = 6'h00;
    tick(1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] v);
    cmd(RD, a, 8'h00);
    look(0, v);
  endtask

  task automatic do_reset(input logic pw, input logic cw);
    cause_pin_wake = pw;
    cause_cmp_wake = cw;
    rst = 1'b1;
    tick(20);
    rst = 1'b0;
  endtask

  // Monitor takes the oldest note whenever a result is due
  always @(posedge sys_clk) begin
    int s;
    logic [7:0] e;
    logic [7:0] o;
    if (probe) begin
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      case (s)
        0: o = reg_rdata;
        1: o = {5'h00, pin_oe};
        2: o = {5'h00, pin_out};
        3: o = {4'h0, pull_en};
        4: o = {7'h00, tmr_ext_sel};
        5: o = {7'h00, wake_req};
        default: o = {7'h00, pin_out[2]};
      endcase
      chk(names[s], o, e);
    end
  end

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (4000) @(posedge sys_clk);
    fail_count++;
    close_out;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, bit_set, bit_clr, dir_load, opt_load} = 6'h00;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    w_reg = 8'h00;
    bit_sel = 3'h0;
    {master_clear_mode, sleep_mode, cmp_en, cmp_out_en} = 4'h0;
    {cmp_out, osc_q_en, osc_q, probe} = 4'h0;
    ext_en = 4'hF;
    ext_val = 4'h0;
    do_reset(1'b1, 1'b0);
    look(1, 8'h00);
    look(4, 8'h01);
    rd(`FPP_OFS_STATUS, 8'h80);
    // Status is not writable from the port side
    cmd(WR, `FPP_OFS_STATUS, 8'hFF);
    rd(`FPP_OFS_STATUS, 8'h80);
    cmd(OL, 5'h00, 8'hDF);
    cmd(WR, `FPP_OFS_PORT, 8'hF5);
    // Reads give pin levels, not the latch, upper nibble zero
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      ext_val = r[3:0];
      tick(5);
      rd(`FPP_OFS_PORT, {4'h0, ext_val});
    end
    ext_en = 4'h8;
    cmd(DL, 5'h00, 8'h08);
    look(1, 8'h07);
    look(2, 8'h05);
    rd(5'h10, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cmd(DL, 5'h00, 8'h0F ^ (8'h01 << i));
      look(1, 8'h01 << i);
    end
    cmd(DL, 5'h00, 8'h08);
    look(2, 8'h05);
    // Pin function precedence
    cmp_en = 1'b1;
    tick(2);
    look(1, 8'h04);
    {osc_q_en, osc_q, cmp_out_en} = 3'b111;
    tick(2);
    look(6, 8'h01);
    osc_q_en = 1'b0;
    tick(2);
    look(6, 8'h00);
    cmp_out_en = 1'b0;
    tick(2);
    look(6, 8'h01);
    cmd(OL, 5'h00, 8'hFF);
    look(4, 8'h01);
    look(1, 8'h00);
    cmp_en = 1'b0;
    tick(2);
    look(1, 8'h03);
    cmd(OL, 5'h00, 8'hDF);
    // Bit operations rewrite latches from the pins
    cmd(DL, 5'h00, 8'h0F);
    ext_en = 4'hF;
    ext_val = 4'h2;
    tick(5);
    cmd(BS, `FPP_OFS_PORT, 8'h00);
    ext_en = 4'h8;
    ext_val = 4'h0;
    cmd(DL, 5'h00, 8'h08);
    look(2, 8'h03);
    tick(5);
    cmd(BC, `FPP_OFS_PORT, 8'h00);
    look(2, 8'h02);
    // Pull-ups and wake on change
    cmd(DL, 5'h00, 8'h0F);
    ext_en = 4'hF;
    cmd(OL, 5'h00, 8'hBF);
    look(3, 8'h0B);
    master_clear_mode = 1'b1;
    cmd(OL, 5'h00, 8'hFF);
    look(3, 8'h08);
    // Wake disabled: a pin 0 change in sleep must not wake
    sleep_mode = 1'b1;
    tick(3);
    ext_val = 4'h1;
    tick(8);
    look(5, 8'h00);
    sleep_mode = 1'b0;
    ext_val = 4'h0;
    tick(8);
    cmd(OL, 5'h00, 8'h7F);
    tick(5);
    sleep_mode = 1'b1;
    tick(3);
    ext_val = 4'h8;
    tick(8);
    look(5, 8'h00);
    ext_val = 4'h9;
    tick(8);
    look(5, 8'h01);
    sleep_mode = 1'b0;
    tick(3);
    look(5, 8'h00);
    // Second reset from driving state, comparator cause
    ext_en = 4'h8;
    cmd(DL, 5'h00, 8'h08);
    do_reset(1'b0, 1'b1);
    look(1, 8'h00);
    rd(`FPP_OFS_STATUS, 8'h40);
    close_out;
  end
endmodule
